// File: svmc_pkg.sv
// shared constants and types of the supply voltage monitor control block
// assumes a 10 mhz system clock and an 8-bit register port with 3 address bits
package svmc_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned HZ_PER_MHZ    = 1_000_000;
  localparam int unsigned RST_DELAY_US  = 100;
  localparam int unsigned RST_DELAY_CYC = RST_DELAY_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned CNT_W         = 11;
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_DELAY_CYC - 1);

  // register indices on the 3-bit port
  localparam logic [2:0] OFS_CMP_IN  = 3'h0;
  localparam logic [2:0] OFS_LEVEL   = 3'h1;
  localparam logic [2:0] OFS_M1_CTL0 = 3'h2;
  localparam logic [2:0] OFS_M2_CTL0 = 3'h3;
  localparam logic [2:0] OFS_M1_CTL1 = 3'h4;
  localparam logic [2:0] OFS_M2_CTL1 = 3'h5;
  localparam logic [2:0] OFS_M1_STAT = 3'h6;
  localparam logic [2:0] OFS_M2_STAT = 3'h7;

  // comparator_input_control field positions
  localparam int unsigned CIC_CE1_BIT  = 0;
  localparam int unsigned CIC_CE2_BIT  = 1;
  localparam int unsigned CIC_REF1_BIT = 4;
  localparam int unsigned CIC_INP1_BIT = 5;
  localparam int unsigned CIC_REF2_BIT = 6;
  localparam int unsigned CIC_INP2_BIT = 7;
  localparam logic [7:0] CIC_RW_MASK   = 8'hf3;

  // detection_level_select layout
  localparam int unsigned LVL1_LSB     = 0;
  localparam int unsigned LVL2_LSB     = 4;
  localparam logic [3:0] LVL_FILT_MIN  = 4'h7;
  localparam logic [3:0] LVL_NOF_MAX   = 4'hd;
  localparam logic [7:0] LVL_NOF_MASK  = 8'h3f;

  // status layout
  localparam int unsigned ST_DET_BIT   = 0;
  localparam int unsigned ST_MON_BIT   = 1;

  // reset values
  localparam logic [7:0] CIC_RST   = 8'h00;
  localparam logic [7:0] LVL_RST   = 8'h77;
  localparam logic [7:0] CTL0_RST  = 8'h00;
  localparam logic [7:0] CTL1_RST  = 8'h00;

  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  typedef struct packed {
    logic       negation_type;
    logic       reset_select;
    logic [1:0] sample_divisor;
    logic       spare;
    logic       output_enable;
    logic       filter_disable;
    logic       irq_reset_enable;
  } svmc_ctl0_t;

  typedef struct packed {
    logic [4:0] spare;
    logic       irq_type_select;
    logic [1:0] irq_edge_select;
  } svmc_ctl1_t;

  typedef struct packed {
    logic       nmi;
    logic       irq;
    logic [1:0] event_out;
  } svmc_req_t;

endpackage

// File: svmc_top.sv
// supply voltage monitor control: three monitors, register port, filters
// assumes comparator outputs and the low-speed oscillator are synchronous to clk
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

// How it works
// - monitor 0 holds reset while below threshold 0, releases after a delay.
// - threshold 0 comes from the option setting word, four levels, no register.
// - monitor 1 level is four bits; without filter codes 0 to 13 only.
// - with filter both level fields accept codes 7 to 15; monitor 2 in bits 7:4.
// - without filter monitor 2 level is two bits in bits 5:4.
// - monitors 1 and 2 show a live above/below flag, read only.
// - monitors 1 and 2 set a sticky crossing flag on either crossing.
// - reset mode holds reset while below; release after delay from rise or drop.
// - interrupt type bit picks non-maskable or maskable request.
// - edge select picks falling, rising or both crossings for requests.
// - monitors 1 and 2 each emit a crossing event for the event link; monitor 0 has none.
// - filter samples at oscillator divided by 1, 2, 4 or 8.
// - both input selects and both reference selects sit in the input register.
module svmc_top #(
  parameter bit HAS_FILTER = 1'b1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // analog side
  input  wire logic [2:0] cmp_above,
  input  wire logic       low_speed_osc,
  input  wire logic [1:0] option_setting_word,
  output logic      [1:0] threshold_0_sel,
  output logic      [7:0] level_sel,
  output logic      [1:0] circuit_enable,
  output logic      [1:0] compare_enable,
  output logic      [3:0] comparator_select,
  // system side
  output logic            chip_reset_req,
  output svmc_pkg::svmc_req_t req
);
  import svmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic lvl_ok(input logic [3:0] code, input logic filt);
    lvl_ok = filt ? (code >= LVL_FILT_MIN) : (code <= LVL_NOF_MAX);
  endfunction

  function automatic logic [3:0] div_last(input logic [1:0] sel);
    div_last = 4'((4'h1 << sel) - 4'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]       cic_r;
  logic [7:0]       lvl_r;
  svmc_ctl0_t [1:0] ctl0_r;
  svmc_ctl1_t [1:0] ctl1_r;
  logic [1:0]       det_r;
  logic [1:0]       filt_r;
  logic [1:0]       prev_r;
  logic [1:0]       smp_r;
  logic [1:0]       act;
  logic [1:0]       rise;
  logic [1:0]       fall;
  logic [1:0]       tick;
  logic [3:0]       div_r [2];
  logic             osc_r;
  logic             osc_edge;
  logic [3:0]       lvl_nxt;
  logic             wr_lvl;

  assign osc_edge = low_speed_osc & ~osc_r;

  // crossing qualified by both enables
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      act[i]  = cic_r[CIC_CE1_BIT + i] & ctl0_r[i].output_enable;
      rise[i] = act[i] & filt_r[i] & ~prev_r[i];
      fall[i] = act[i] & ~filt_r[i] & prev_r[i];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cic_r <= CIC_RST;
    end else if (reg_wr && reg_addr == OFS_CMP_IN) begin
      // reference and input selects exist only with the filter build
      cic_r <= reg_wdata & (HAS_FILTER ? CIC_RW_MASK : 8'h03);
    end
  end

  // prohibited level codes leave the field unchanged
  always_comb begin
    wr_lvl  = reg_wr && reg_addr == OFS_LEVEL;
    lvl_nxt = reg_wdata[LVL2_LSB +: 4];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_r <= LVL_RST;
    end else if (wr_lvl) begin
      if (lvl_ok(reg_wdata[LVL1_LSB +: 4], HAS_FILTER)) begin
        lvl_r[LVL1_LSB +: 4] <= reg_wdata[LVL1_LSB +: 4];
      end
      if (HAS_FILTER) begin
        if (lvl_ok(lvl_nxt, 1'b1)) begin
          lvl_r[LVL2_LSB +: 4] <= lvl_nxt;
        end
      end else begin
        lvl_r[LVL2_LSB +: 2] <= lvl_nxt[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl0_r <= {CTL0_RST, CTL0_RST};
      ctl1_r <= {CTL1_RST, CTL1_RST};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && reg_addr == OFS_M1_CTL0 + 3'(i)) begin
          ctl0_r[i] <= reg_wdata;
          ctl0_r[i].spare <= 1'b0;
          if (!HAS_FILTER) begin
            ctl0_r[i].sample_divisor <= 2'h0;
            ctl0_r[i].filter_disable <= 1'b1;
          end
        end
        if (reg_wr && reg_addr == OFS_M1_CTL1 + 3'(i)) begin
          ctl1_r[i] <= {5'h00, reg_wdata[2:0]};
        end
      end
    end
  end

  // sticky flags: a crossing in the clearing cycle still sets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      det_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise[i] || fall[i]) begin
          det_r[i] <= 1'b1;
        end else if (reg_wr && reg_addr == OFS_M1_STAT + 3'(i)
                     && !reg_wdata[ST_DET_BIT]) begin
          det_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data only in the cycle after the strobe

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CMP_IN:  reg_rdata <= cic_r;
        OFS_LEVEL:   reg_rdata <= lvl_r;
        OFS_M1_CTL0: reg_rdata <= ctl0_r[0];
        OFS_M2_CTL0: reg_rdata <= ctl0_r[1];
        OFS_M1_CTL1: reg_rdata <= ctl1_r[0];
        OFS_M2_CTL1: reg_rdata <= ctl1_r[1];
        OFS_M1_STAT: reg_rdata <= {6'h00, filt_r[0], det_r[0]};
        OFS_M2_STAT: reg_rdata <= {6'h00, filt_r[1], det_r[1]};
        default:     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling clock and filter

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_r <= 1'b0;
    end else begin
      osc_r <= low_speed_osc;
    end
  end

  // one tick every n oscillator periods
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r[0] <= 4'h0;
      div_r[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (osc_edge) begin
          if (div_r[i] >= div_last(ctl0_r[i].sample_divisor)) begin
            div_r[i] <= 4'h0;
          end else begin
            div_r[i] <= div_r[i] + 4'h1;
          end
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tick[i] = osc_edge && div_r[i] >= div_last(ctl0_r[i].sample_divisor);
    end
  end

  // two agreeing samples needed, so a glitch shorter than a period is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smp_r  <= 2'h0;
      filt_r <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      prev_r <= filt_r;
      for (int i = 0; i < 2; i++) begin
        if (!HAS_FILTER || ctl0_r[i].filter_disable) begin
          smp_r[i]  <= cmp_above[i+1];
          filt_r[i] <= cmp_above[i+1];
        end else if (tick[i]) begin
          smp_r[i] <= cmp_above[i+1];
          if (smp_r[i] == cmp_above[i+1]) begin
            filt_r[i] <= cmp_above[i+1];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // requests and events

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req <= '0;
    end else begin
      req <= '0;
      for (int i = 0; i < 2; i++) begin
        req.event_out[i] <= rise[i] | fall[i];
        if (ctl0_r[i].irq_reset_enable && !ctl0_r[i].reset_select) begin
          if ((rise[i] && ctl1_r[i].irq_edge_select != EDGE_FALL) ||
              (fall[i] && ctl1_r[i].irq_edge_select != EDGE_RISE)) begin
            if (ctl1_r[i].irq_type_select) begin
              req.irq <= 1'b1;
            end else begin
              req.nmi <= 1'b1;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing for all three monitors

  logic [2:0]       rst_r;
  logic [CNT_W-1:0] rcnt_r [3];
  logic [1:0]       mode_rst;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_rst[i] = act[i] & ctl0_r[i].irq_reset_enable & ctl0_r[i].reset_select;
    end
  end

  // monitor 0 starts asserted so the chip waits the full delay after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_r     <= 3'h1;
      rcnt_r[0] <= '0;
      rcnt_r[1] <= '0;
      rcnt_r[2] <= '0;
    end else begin
      if (!cmp_above[0]) begin
        rst_r[0]  <= 1'b1;
        rcnt_r[0] <= '0;
      end else if (rst_r[0]) begin
        if (rcnt_r[0] == RST_LAST) begin
          rst_r[0] <= 1'b0;
        end
        rcnt_r[0] <= rcnt_r[0] + 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (!mode_rst[i]) begin
          rst_r[i+1]  <= 1'b0;
          rcnt_r[i+1] <= '0;
        end else if (fall[i] ||
                     (!filt_r[i] && !ctl0_r[i].negation_type)) begin
          rst_r[i+1]  <= 1'b1;
          rcnt_r[i+1] <= '0;
        end else if (rst_r[i+1] && (filt_r[i] || ctl0_r[i].negation_type)) begin
          if (rcnt_r[i+1] == RST_LAST) begin
            rst_r[i+1] <= 1'b0;
          end
          rcnt_r[i+1] <= rcnt_r[i+1] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chip_reset_req <= 1'b1;
    end else begin
      chip_reset_req <= |rst_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls

  // the option word is a strap, caught after release rather than under reset
  logic strap_done_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_done_r    <= 1'b0;
      threshold_0_sel <= 2'h0;
    end else if (!strap_done_r) begin
      strap_done_r    <= 1'b1;
      threshold_0_sel <= option_setting_word;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_sel         <= LVL_RST;
      circuit_enable    <= 2'h0;
      compare_enable    <= 2'h0;
      comparator_select <= 4'h0;
    end else begin
      level_sel         <= HAS_FILTER ? lvl_r : (lvl_r & LVL_NOF_MASK);
      circuit_enable    <= {cic_r[CIC_CE2_BIT], cic_r[CIC_CE1_BIT]};
      compare_enable    <= {ctl0_r[1].output_enable, ctl0_r[0].output_enable};
      comparator_select <= {cic_r[CIC_INP2_BIT], cic_r[CIC_REF2_BIT],
                            cic_r[CIC_INP1_BIT], cic_r[CIC_REF1_BIT]};
    end
  end

endmodule

// File: svmc_props.sv
// checker of the supply monitor control top ports
// assumes binding onto svmc_top, one clock domain
`timescale 1ns/1ps
module svmc_props
  import svmc_pkg::*;
#(
  parameter bit HAS_FILTER = 1'b1
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // analog side
  input wire logic [2:0] cmp_above,
  input wire logic       low_speed_osc,
  input wire logic [1:0] option_setting_word,
  input wire logic [1:0] threshold_0_sel,
  input wire logic [7:0] level_sel,
  input wire logic [1:0] circuit_enable,
  input wire logic [1:0] compare_enable,
  input wire logic [3:0] comparator_select,
  // system side
  input wire logic       chip_reset_req,
  input svmc_req_t       req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [10:0] above_r;
  // saturates, so a long run above threshold never wraps under the bound
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      above_r <= 11'h000;
    end else if (!cmp_above[0]) begin
      above_r <= 11'h000;
    end else if (above_r != 11'h7ff) begin
      above_r <= above_r + 11'h001;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_RST_HOLD: assert property (!cmp_above[0] |-> ##[1:2] chip_reset_req)
    else $error("chip reset not held while supply low");
  AST_RST_DELAY: assert property ($fell(chip_reset_req) |-> above_r >= 11'd999)
    else $error("chip reset released too early");
  AST_SEL_STRAP: assert property ($past(nrst)
    |-> threshold_0_sel == $past(option_setting_word))
    else $error("threshold 0 select differs from strap");
  AST_LVL_READ: assert property (reg_rd && reg_addr == OFS_LEVEL |=> reg_rdata == level_sel)
    else $error("level read data wrong");
  // level_sel trails the register by one cycle, so the write shows two edges on
  AST_LVL_WRITE: assert property (HAS_FILTER && reg_wr && reg_addr == OFS_LEVEL
    && reg_wdata[3:0] >= LVL_FILT_MIN |-> ##2 level_sel[3:0] == $past(reg_wdata[3:0], 2))
    else $error("valid level code not taken");
  AST_LVL_KEEP: assert property (HAS_FILTER && reg_wr && reg_addr == OFS_LEVEL
    && reg_wdata[3:0] < LVL_FILT_MIN |-> ##2 $stable(level_sel[3:0]))
    else $error("prohibited level code taken");
  AST_CIC_READ: assert property (reg_rd && reg_addr == OFS_CMP_IN
    |=> reg_rdata == {comparator_select, 2'h0, circuit_enable})
    else $error("input control read data wrong");
  // both enable copies lag their registers by the same cycle as the event
  AST_EVT_GATE: assert property (req.event_out[0]
    |-> circuit_enable[0] && compare_enable[0])
    else $error("event while monitor inactive");
  AST_IRQ_EVT: assert property ((req.irq | req.nmi) |-> |req.event_out)
    else $error("request without crossing");
  cover property (req.irq);
  cover property (req.nmi);
  cover property ($fell(chip_reset_req));
endmodule

bind svmc_top svmc_props #(.HAS_FILTER(HAS_FILTER)) i_props (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above(cmp_above),
  .low_speed_osc(low_speed_osc), .option_setting_word(option_setting_word),
  .threshold_0_sel(threshold_0_sel), .level_sel(level_sel),
  .circuit_enable(circuit_enable), .compare_enable(compare_enable),
  .comparator_select(comparator_select), .chip_reset_req(chip_reset_req), .req(req)
);

// File: svmc_analog_model.sv
// analog side model: three comparators and the low-speed oscillator
// assumes target levels from the bench; outputs synchronous to clk
`timescale 1ns/1ps
module svmc_analog_model (
  // clock
  input  wire logic       clk,
  // wanted comparator levels
  input  wire logic [2:0] target,
  // to the block
  output logic      [2:0] cmp_above,
  output logic            low_speed_osc
);
  logic [2:0] osc_cnt_r = 3'h0;
  // one cycle of settling, so no change reaches the block at once
  always @(posedge clk) begin
    cmp_above <= target;
    osc_cnt_r <= osc_cnt_r + 3'h1;
  end
  // oscillator runs free at an eighth of clk
  assign low_speed_osc = osc_cnt_r[2];
endmodule

// File: testbench.sv
// self-checking bench of the supply monitor control block
// assumes the analog model beside it and the filter build of the top
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import svmc_pkg::*;
  localparam int T_EA = 20;
  logic            clk, nrst, reg_wr, reg_rd, osc, crr;
  logic      [2:0] reg_addr, cmp_above, target;
  logic      [7:0] reg_wdata, reg_rdata, lvl;
  logic      [1:0] osw, t0sel, cen, coe;
  logic      [3:0] csel;
  svmc_req_t       req;
  int              errors, cmp_count, n_irq, n_nmi, n_evt0, n_evt1;
  logic      [7:0] dflt [6] = '{CIC_RST, LVL_RST, CTL0_RST, CTL0_RST, CTL1_RST, CTL1_RST};

  svmc_analog_model i_ana (.clk(clk), .target(target), .cmp_above(cmp_above),
    .low_speed_osc(osc));
  svmc_top #(.HAS_FILTER(1'b1)) i_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above(cmp_above),
    .low_speed_osc(osc), .option_setting_word(osw), .threshold_0_sel(t0sel),
    .level_sel(lvl), .circuit_enable(cen), .compare_enable(coe),
    .comparator_select(csel), .chip_reset_req(crr), .req(req));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    n_irq  += int'(req.irq === 1'b1);
    n_nmi  += int'(req.nmi === 1'b1);
    n_evt0 += int'(req.event_out[0] === 1'b1);
    n_evt1 += int'(req.event_out[1] === 1'b1);
  end

  function automatic int exp_irq(input logic [1:0] e);
    return (e == EDGE_RISE || e == EDGE_FALL) ? 1 : 2;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // an idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #10;
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic wait_rel(output int c);
    c = 0;
    while (crr !== 1'b0 && c < 3000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 3000) begin
      errors++;
      close_out();
    end
  endtask
  task automatic hold_rel(input int i);
    int c;
    target[i] <= 1'b0;
    cyc(5);
    `CHK(crr, 1'b1)
    target[i] <= 1'b1;
    wait_rel(c);
    `CHK(c > 990 && c < 1010, 1'b1)
  endtask
  task automatic pulse(input int i);
    target[i] <= 1'b0;
    cyc(10);
    target[i] <= 1'b1;
    cyc(10);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    int c, m;
    logic [7:0] r, d;
    logic [3:0] a, b;
    void'($urandom(51));
    nrst = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    target = 3'h7;
    osw = 2'($urandom);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    `CHK(crr, 1'b1)
    wait_rel(c);
    `CHK(c > 990 && c < 1010, 1'b1)
    `CHK(t0sel, osw)
    hold_rel(0);
    $display("test chip reset finished");
    foreach (dflt[i]) begin
      rd(3'(i), r);
      `CHK(r, dflt[i])
    end
    repeat (4) begin
      d = 8'($urandom);
      wr(OFS_CMP_IN, d);
      rd(OFS_CMP_IN, r);
      `CHK(r, d & CIC_RW_MASK)
    end
    wr(OFS_CMP_IN, 8'h00);
    repeat (5) begin
      a = 4'(7 + $urandom % 9);
      b = 4'(7 + $urandom % 9);
      wr(OFS_LEVEL, {b, a});
      rd(OFS_LEVEL, r);
      `CHK(r, {b, a})
    end
    wr(OFS_LEVEL, {4'h6, 4'hf});
    rd(OFS_LEVEL, r);
    `CHK(r, {b, 4'hf})
    wr(OFS_LEVEL, {4'h9, 4'h2});
    rd(OFS_LEVEL, r);
    `CHK(r, {4'h9, 4'hf})
    rd(OFS_M1_STAT, r);
    `CHK(r[ST_MON_BIT], 1'b1)
    `CHK(r[ST_DET_BIT], 1'b0)
    $display("test registers finished");
    wr(OFS_LEVEL, 8'h7a);
    wr(OFS_M1_CTL0, 8'h02);
    wr(OFS_CMP_IN, 8'h01);
    cyc(T_EA);
    wr(OFS_M1_CTL0, 8'h06);
    cyc(20);
    wr(OFS_M1_STAT, 8'h00);
    wr(OFS_M1_CTL0, 8'h07);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_M1_CTL1, 8'(k));
      n_irq = 0;
      n_nmi = 0;
      n_evt0 = 0;
      pulse(1);
      `CHK(n_irq, k[2] ? exp_irq(k[1:0]) : 0)
      `CHK(n_nmi, k[2] ? 0 : exp_irq(k[1:0]))
      `CHK(n_evt0, 2)
    end
    rd(OFS_M1_STAT, r);
    `CHK(r[ST_DET_BIT], 1'b1)
    wr(OFS_M1_STAT, 8'h00);
    rd(OFS_M1_STAT, r);
    `CHK(r[ST_DET_BIT], 1'b0)
    wr(OFS_M1_CTL0, 8'h03);
    n_evt0 = 0;
    pulse(1);
    `CHK(n_evt0, 0)
    $display("test interrupts finished");
    wr(OFS_M1_CTL0, 8'h47);
    hold_rel(1);
    wr(OFS_M1_CTL0, 8'hc7);
    target[1] <= 1'b0;
    cyc(5);
    wait_rel(c);
    `CHK(c > 980 && c < 1010, 1'b1)
    target[1] <= 1'b1;
    wr(OFS_M1_CTL0, 8'h06);
    $display("test monitor reset finished");
    wr(OFS_CMP_IN, 8'h01);
    for (int n = 0; n < 4; n++) begin
      m = 1 << n;
      wr(OFS_M2_CTL0, 8'h02 | 8'(n << 4));
      wr(OFS_CMP_IN, 8'h03);
      cyc(T_EA);
      wr(OFS_M2_CTL0, 8'h06 | 8'(n << 4));
      cyc(8);
      wr(OFS_M2_CTL0, 8'h05 | 8'(n << 4));
      cyc(40 * m);
      wr(OFS_M2_STAT, 8'h00);
      n_evt1 = 0;
      target[2] <= 1'b0;
      cyc(2);
      target[2] <= 1'b1;
      cyc(40 * m);
      `CHK(n_evt1, 0)
      target[2] <= 1'b0;
      cyc(6 * m);
      `CHK(n_evt1, 0)
      cyc(10 * m + 8);
      `CHK(n_evt1, 1)
      target[2] <= 1'b1;
      cyc(20 * m + 8);
      wr(OFS_CMP_IN, 8'h01);
    end
    $display("test filter finished");
    close_out();
  end
endmodule
